// ### core/isb_irq_ctrl.sv
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
module isb_irq_ctrl
  import isb_pkg::*;
#(
  parameter int SYNC_GROUP = 3
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  ext_request_pins,
  input  wire logic [1:0]  pin_share_sel,
  input  wire logic [1:0]  pin_dir_input,
  input  wire logic [1:0]  pull_high_sel,
  output logic [1:0]       pull_high_en,
  input  wire logic [3:0]  grp_src_set,
  input  wire logic        conv_done,
  input  wire logic [5:0]  serial_events,
  input  wire logic        sync_serial_event,
  input  wire logic        sub_tick,
  input  wire logic        stack_full,
  input  wire logic        return_from_irq,
  output logic             irq_call,
  output logic [3:0]       irq_vector,
  output logic             wake,
  output logic             global_irq_enable
);
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [NUM_FLAGS-1:0] flags_q, flags_d, en_q, set_v, clr_v;
  logic [3:0]  edge_select_reg_q;
  logic [1:0]  prescaler_source_sel_q;
  logic [3:0]  tick0_q, tick1_q;
  logic [1:0]  pin_prev_q;
  logic [1:0]  div4_q;
  logic        prescaler_clock;
  logic [TICK_CNT_W-1:0] cnt0_q, cnt1_q;
  logic        ovf0, ovf1;
  logic        wr_en, rd_ok, sync_rise;
  logic [NUM_VEC-1:0] pend;
  logic        call_now;
  logic [3:0]  vec_sel;

  assign wr_en = psel & penable & pwrite & pready;
  always_comb begin
    unique case (paddr)
      ADDR_CTRL, ADDR_ENABLE, ADDR_FLAGS, ADDR_EDGE,
      ADDR_PSC, ADDR_TICK0, ADDR_TICK1: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev, input logic now);
    unique case (sel)
      EDGE_RISE: edge_hit = ~prev & now;
      EDGE_FALL: edge_hit = prev & ~now;
      EDGE_BOTH: edge_hit = prev ^ now;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // Overflow once per 2^(8+period) prescaler clocks; low bits all ones.
  function automatic logic tick_ovf(input logic [TICK_CNT_W-1:0] cnt,
                                    input logic [2:0] period);
    logic [TICK_CNT_W-1:0] mask;
    mask = TICK_CNT_W'((32'd1 << (PERIOD_MIN_LOG2 + int'(period))) - 1);
    tick_ovf = ((cnt & mask) == mask);
  endfunction

  // ****************************************************************
  // APB slave, one wait state so read data leaves a flip-flop
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~rd_ok;
      prdata  <= 32'h0000_0000;
      if (~pwrite) begin
        unique case (paddr)
          ADDR_CTRL:   prdata[0] <= global_irq_enable;
          ADDR_ENABLE: prdata[NUM_FLAGS-1:0] <= en_q;
          ADDR_FLAGS:  prdata[NUM_FLAGS-1:0] <= flags_q;
          ADDR_EDGE:   prdata[3:0] <= edge_select_reg_q;
          ADDR_PSC:    prdata[1:0] <= prescaler_source_sel_q;
          ADDR_TICK0:  prdata[7:0] <= {tick0_q[3], 4'h0, tick0_q[2:0]};
          ADDR_TICK1:  prdata[7:0] <= {tick1_q[3], 4'h0, tick1_q[2:0]};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_q                   <= FLAGS_RST;
      edge_select_reg_q      <= EDGE_RST;
      prescaler_source_sel_q <= PSC_RST;
      tick0_q                <= TICK_RST;
      tick1_q                <= TICK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_ENABLE: en_q <= pwdata[NUM_FLAGS-1:0];
        ADDR_EDGE:   edge_select_reg_q <= pwdata[3:0];
        ADDR_PSC:    prescaler_source_sel_q <= pwdata[1:0];
        ADDR_TICK0:  tick0_q <= {pwdata[TICK_ON_BIT], pwdata[2:0]};
        ADDR_TICK1:  tick1_q <= {pwdata[TICK_ON_BIT], pwdata[2:0]};
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Prescaler and tick dividers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) div4_q <= 2'd0;
    else      div4_q <= div4_q + 2'd1;
  end

  always_comb begin
    if (prescaler_source_sel_q[1]) prescaler_clock = sub_tick;
    else if (prescaler_source_sel_q[0])
      prescaler_clock = (div4_q == 2'(SYS_DIV4 - 1));
    else prescaler_clock = 1'b1;
  end

  assign ovf0 = tick0_q[3] & prescaler_clock & tick_ovf(cnt0_q, tick0_q[2:0]);
  assign ovf1 = tick1_q[3] & prescaler_clock & tick_ovf(cnt1_q, tick1_q[2:0]);

  // Counters rest at zero while off so the first period is whole.
  always_ff @(posedge ref_clk) begin
    if (srst | ~tick0_q[3]) cnt0_q <= '0;
    else if (prescaler_clock) cnt0_q <= cnt0_q + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst | ~tick1_q[3]) cnt1_q <= '0;
    else if (prescaler_clock) cnt1_q <= cnt1_q + 1'b1;
  end

  // ****************************************************************
  // Request flags
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) pin_prev_q <= 2'b00;
    else      pin_prev_q <= ext_request_pins;
  end

  // Enabled sync serial flag rising feeds its grouped channel once.
  assign sync_rise = set_v[BIT_SYNC] & ~flags_q[BIT_SYNC]
                   & en_q[BIT_SYNC];

  always_comb begin
    set_v = '0;
    for (int i = 0; i < 2; i++) begin
      set_v[BIT_EXT0+i] = en_q[BIT_EXT0+i] & pin_share_sel[i]
        & pin_dir_input[i]
        & edge_hit(edge_select_reg_q[2*i +: 2], pin_prev_q[i],
                   ext_request_pins[i]);
    end
    set_v[BIT_SYNC]  = sync_serial_event;
    set_v[BIT_CONV]  = conv_done;
    set_v[BIT_TICK0] = ovf0;
    set_v[BIT_TICK1] = ovf1;
    set_v[BIT_SER]   = |serial_events;
    set_v[BIT_GRP0 +: 4] = grp_src_set;
    set_v[BIT_GRP0 + SYNC_GROUP] = grp_src_set[SYNC_GROUP] | sync_rise;
  end

  // Fixed priority: lowest bit position wins.
  always_comb begin
    pend = flags_q[NUM_VEC-1:0] & en_q[NUM_VEC-1:0];
    vec_sel = 4'd0;
    for (int i = NUM_VEC - 1; i >= 0; i--)
      if (pend[i]) vec_sel = 4'(i);
  end

  // Calls are spaced by the enable clear, so one vector per service.
  assign call_now = global_irq_enable & (|pend) & ~stack_full;

  always_comb begin
    clr_v = '0;
    if (call_now) clr_v[vec_sel] = 1'b1;
  end

  // Hardware sets win over service clears and software writes.
  always_comb begin
    flags_d = flags_q;
    if (wr_en && paddr == ADDR_FLAGS) flags_d = pwdata[NUM_FLAGS-1:0];
    flags_d = (flags_d & ~clr_v) | set_v;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_q <= FLAGS_RST;
      wake    <= 1'b0;
    end else begin
      flags_q <= flags_d;
      wake    <= |(flags_d & ~flags_q);
    end
  end

  // ****************************************************************
  // Global enable and core handshake
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) global_irq_enable <= 1'b0;
    else if (call_now) global_irq_enable <= 1'b0;
    else if (return_from_irq) global_irq_enable <= 1'b1;
    else if (wr_en && paddr == ADDR_CTRL) global_irq_enable <= pwdata[0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_call     <= 1'b0;
      irq_vector   <= 4'd0;
      pull_high_en <= 2'b00;
    end else begin
      irq_call     <= call_now;
      if (call_now) irq_vector <= vec_sel;
      pull_high_en <= pull_high_sel;
    end
  end

endmodule // isb_irq_ctrl

// ### core/isb_pkg.sv
// Function
// - External pin flag sets on the edge chosen for that pin.
// - External pin vector needs global enable and pin enable.
// - Pin acts as request input only if enabled, selected, and input.
// - Servicing an external pin clears its flag and the global enable.
// - Edge select offers off, rising, falling or both edges.
// - A pending enabled request is called only while the stack is not full.
// - Up to four grouped channels, set when any contained source flags; the sync source feeds its group only while enabled.
// - Grouped service clears only grouped flag and global enable.
// - Converter flag sets on done; vector needs global and own enable.
// - Servicing converter request clears its flag and global enable.
// - Tick flag sets on divider overflow; vector needs both enables.
// - Servicing a tick request clears its flag and global enable.
// - Prescaler source: 00 system, 01 system/4, 1x sub clock.
// - Bit 7 of a tick control enables that generator; resets to 0.
// - Tick zero period field selects 2^8 to 2^15 prescaler clocks.
// - Tick one has its own identical period field, same prescaler.
// - Serial flag rises on any of six serial events.
// - Servicing serial request clears its flag and global enable.
// - Sync serial flag sets per byte, match or time-out; feeds a group only while its enable is set.
// - Pull-high selection stays in effect on request input pins.
// - Flags set even when disabled, except external pin flags, which need their enable; global enable off blocks all calls.
// - Any flag rising wakes the device regardless of enables.
// - Return-from-irq sets the global enable; plain return does not.
package isb_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_FLAGS  = 8'h08;
  localparam logic [7:0] ADDR_EDGE   = 8'h0C;
  localparam logic [7:0] ADDR_PSC    = 8'h10;
  localparam logic [7:0] ADDR_TICK0  = 8'h14;
  localparam logic [7:0] ADDR_TICK1  = 8'h18;
  // Flag and enable bit positions; the lower ten also give vector order.
  localparam int BIT_EXT0  = 0;
  localparam int BIT_EXT1  = 1;
  localparam int BIT_GRP0  = 2;
  localparam int BIT_CONV  = 6;
  localparam int BIT_TICK0 = 7;
  localparam int BIT_TICK1 = 8;
  localparam int BIT_SER   = 9;
  localparam int BIT_SYNC  = 10;
  localparam int NUM_FLAGS = 11;
  localparam int NUM_VEC   = 10;
  localparam int TICK_ON_BIT = 7;
  localparam int PERIOD_MIN_LOG2 = 8;
  localparam int TICK_CNT_W = 15;
  localparam int SYS_DIV4 = 4;
  localparam logic [1:0] EDGE_OFF  = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 11'h000;
  localparam logic [3:0] EDGE_RST = 4'h0;
  localparam logic [1:0] PSC_RST = 2'h0;
  localparam logic [3:0] TICK_RST = 4'h0;
endpackage

// ### testbench/isb_core_model.sv
`timescale 1ns/10ps
module isb_core_model #(
  parameter int STACK_DEPTH = 2,
  parameter int RET_DELAY   = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic irq_call,
  input wire logic hold_full,
  output logic     stack_full,
  output logic     return_from_irq
);
  // ****************************************
  // Stack and return timing
  // ****************************************
  logic [3:0] depth_q;
  logic [3:0] wait_q;
  // The bench can pin the stack full to hold off every call.
  assign stack_full = hold_full || depth_q == 4'(STACK_DEPTH);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      depth_q <= 4'h0;
      wait_q <= 4'h0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= 1'b0;
      if (irq_call) begin
        depth_q <= depth_q + 4'h1;
        wait_q <= 4'(RET_DELAY);
      end else if (wait_q == 4'h1) begin
        return_from_irq <= 1'b1;
        depth_q <= depth_q - 4'h1;
        wait_q <= 4'h0;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule // isb_core_model

// ### testbench/isb_irq_ctrl_assertions.sv
`timescale 1ns/10ps
module isb_checker
  import isb_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [1:0] pull_high_sel,
  input wire logic [1:0] pull_high_en,
  input wire logic       stack_full,
  input wire logic       return_from_irq,
  input wire logic       irq_call,
  input wire logic [3:0] irq_vector,
  input wire logic       wake,
  input wire logic       global_irq_enable
);
  // ****************************************
  // Call and enable relations
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_call_needs_global: assert property (
    irq_call |-> $past(global_irq_enable)) else $error("call while off");
  a_call_stack_free: assert property (
    irq_call |-> !$past(stack_full)) else $error("call on full stack");
  a_call_clears_global: assert property (
    irq_call |-> !global_irq_enable) else $error("enable kept on call");
  a_one_vector: assert property (
    irq_call |=> !irq_call) else $error("two calls in a row");
  a_vector_in_range: assert property (
    irq_call |-> irq_vector < 4'd10) else $error("vector out of range");
  a_vector_holds: assert property (
    !irq_call |-> $stable(irq_vector)) else $error("vector moved");
  a_return_from_irq_sets_global: assert property (
    return_from_irq |=> global_irq_enable || irq_call)
    else $error("return left enable off");
  a_global_has_cause: assert property (
    $rose(global_irq_enable) |-> $past(return_from_irq) ||
      $past(pready && pwrite && paddr == ADDR_CTRL))
    else $error("enable rose unasked");
  a_pull_kept: assert property (
    !srst |=> pull_high_en == $past(pull_high_sel))
    else $error("pull-high lost");
  c_last_vector: cover property (irq_call && irq_vector == 4'd9);
  c_wake: cover property (wake);
  c_refused: cover property (pready && pslverr);
endmodule // isb_checker

bind isb_irq_ctrl isb_checker u_chk (.ref_clk, .srst, .pwrite, .paddr,
  .pready, .pslverr, .pull_high_sel, .pull_high_en, .stack_full,
  .return_from_irq, .irq_call, .irq_vector, .wake, .global_irq_enable);

// ### testbench/isb_irq_ctrl_test.sv
`timescale 1ns/10ps
module isb_irq_ctrl_test;
  import isb_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic conv_done = 0, sync_serial_event = 0, sub_tick = 0, hold = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, stack_full, return_from_irq, irq_call, wake;
  logic global_irq_enable;
  logic [1:0] ext_request_pins = 0, pin_share_sel = 1, pin_dir_input = 1;
  logic [1:0] pull_high_sel = 2, pull_high_en;
  logic [3:0] grp_src_set = 0, irq_vector, last_v;
  logic [5:0] serial_events = 0;
  int bad_count = 0, n_tests = 0, cyc = 0, calls = 0, n, t0, t1;
  int wakes = 0, w;
  int tp[4] = '{0, 1, 2, 0}, tv[4] = '{'h80, 'h80, 'h81, 'h82};
  int te[4] = '{256, 1024, 1024, 1024};
  isb_irq_ctrl dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_request_pins, .pin_share_sel,
    .pin_dir_input, .pull_high_sel, .pull_high_en, .grp_src_set, .conv_done,
    .serial_events, .sync_serial_event, .sub_tick, .stack_full,
    .return_from_irq, .irq_call, .irq_vector, .wake, .global_irq_enable);
  isb_core_model core (.ref_clk, .srst, .irq_call, .hold_full(hold),
    .stack_full, .return_from_irq);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sub_tick <= ~sub_tick;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (irq_call === 1'b1) begin
      calls <= calls + 1;
      last_v <= irq_vector;
      t1 <= cyc;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(k < 20, 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(r, x);
  endtask
  task automatic wc(input int m);
    int k;
    k = 0;
    while (calls < m && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < 3000, 1);
  endtask
  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 0;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 0);
    rd(8'h1C, 0);
    chk(e, 1);
    $display("test reset done");
    apb(1, ADDR_ENABLE, 1);
    for (int m = 0; m < 4; m++) begin
      apb(1, ADDR_EDGE, m);
      apb(1, ADDR_FLAGS, 0);
      ext_request_pins[0] <= 1;
      rd(ADDR_FLAGS, m & 1);
      apb(1, ADDR_FLAGS, 0);
      ext_request_pins[0] <= 0;
      rd(ADDR_FLAGS, m >> 1);
    end
    apb(1, ADDR_FLAGS, 0);
    pin_dir_input <= 0;
    ext_request_pins[0] <= 1;
    rd(ADDR_FLAGS, 0);
    $display("test edges done");
    apb(1, ADDR_ENABLE, 32'h0000_0400);
    w = wakes;
    conv_done <= 1; sync_serial_event <= 1; grp_src_set <= 7;
    serial_events <= 6'h20;
    @(posedge ref_clk);
    conv_done <= 0; sync_serial_event <= 0; grp_src_set <= 0;
    serial_events <= 0;
    rd(ADDR_FLAGS, 32'h0000_067C);
    chk(wakes, w + 1);
    apb(1, ADDR_ENABLE, 32'h0000_0620);
    n = calls;
    apb(1, ADDR_CTRL, 1);
    wc(n + 1);
    chk(last_v, 5);
    wc(n + 2);
    chk(last_v, BIT_SER);
    rd(ADDR_FLAGS, 32'h0000_045C);
    apb(1, ADDR_FLAGS, 0);
    $display("test grouped done");
    hold <= 1;
    apb(1, ADDR_ENABLE, 32'h0000_0040);
    n = calls;
    conv_done <= 1;
    @(posedge ref_clk);
    conv_done <= 0;
    repeat (20) @(posedge ref_clk);
    chk(calls, n);
    hold <= 0;
    wc(n + 1);
    chk(last_v, BIT_CONV);
    rd(ADDR_FLAGS, 0);
    apb(1, ADDR_ENABLE, 32'h0000_03FF);
    n = calls;
    apb(1, ADDR_FLAGS, 32'h0000_03FF);
    for (int i = 0; i < NUM_VEC; i++) begin
      wc(n + i + 1);
      chk(last_v, i);
    end
    rd(ADDR_FLAGS, 0);
    $display("test priority done");
    apb(1, ADDR_ENABLE, 32'h0000_0180);
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_PSC, tp[i]);
      apb(1, i < 2 ? ADDR_TICK0 : ADDR_TICK1, tv[i]);
      n = calls;
      wc(n + 1);
      t0 = t1;
      wc(n + 2);
      chk(t1 - t0, te[i]);
      chk(last_v, BIT_TICK0 + i / 2);
      apb(1, i < 2 ? ADDR_TICK0 : ADDR_TICK1, 0);
      apb(1, ADDR_FLAGS, 0);
    end
    $display("test ticks done");
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    $display("mismatch at %0t: run hung", $time);
    tally_and_finish;
  end
endmodule // isb_irq_ctrl_test
